// ### src/coos_defs.svh
// Field positions, encodings, widths and reset value of the sequencer
`ifndef COOS_DEFS_SVH
`define COOS_DEFS_SVH

// Conversion command layout
`define COOS_CMD_ON_BIT 7
`define COOS_CMD_MRG_HI 5
`define COOS_CMD_MRG_LO 4
`define COOS_CMD_RESET 8'h00
`define COOS_MRG_FLD_LOW 2'h1
`define COOS_MRG_FLD_HIGH 2'h2

// Gating policy encodings
`define COOS_GATE_UVLO 2'h0
`define COOS_GATE_PIN 2'h1
`define COOS_GATE_CMD 2'h2
`define COOS_GATE_BOTH 2'h3

// Widths
`define COOS_DLY_W 8
`define COOS_SS_W 16

`endif

// ### src/coos_pkg.sv
// Types shared by the on/off sequencer
package coos_pkg;
    typedef enum logic [2:0] {
        COOS_OFF,
        COOS_ON_WAIT,
        COOS_SOFT_START,
        COOS_ON,
        COOS_OFF_WAIT
    } coos_state_t;

    typedef enum logic [1:0] {
        COOS_MARGIN_NONE,
        COOS_MARGIN_HIGH,
        COOS_MARGIN_LOW
    } coos_margin_t;
endpackage

// ### src/coos_period_tick.sv
// Soft-start period ticker: one-cycle pulse per soft-start duration
`timescale 1ns/1ps
`include "coos_defs.svh"

module coos_period_tick (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic restart_i,
    input wire logic [`COOS_SS_W-1:0] period_i,
    output logic tick_o
);
    logic [`COOS_SS_W-1:0] cnt_reg;
    logic [`COOS_SS_W-1:0] cnt_next;
    logic [`COOS_SS_W-1:0] last;

    // A zero period is treated as one cycle so that delays always advance
    assign last = (period_i == '0) ? '0 : period_i - `COOS_SS_W'(1);
    // Tick reads only the count register and period_i: gating it with restart_i would
    // close a loop through the sequencer's next-state logic
    // Greater-or-equal recovers at once if the period shrinks mid-count
    assign tick_o = (cnt_reg >= last);

    always_comb begin
        if (restart_i || tick_o) begin
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + `COOS_SS_W'(1);
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ### src/coos_sequencer.sv
// On/off sequencer: gating, turn-on/off delays, power-good release
`timescale 1ns/1ps
`include "coos_defs.svh"

// What this block does
// - Start once input rises above UVLO
// - Optionally also need pin or command
// - Gate on pin, command, or both
// - Wait turn-on delay before regulating
// - Wait turn-off delay before stopping
// - Delays counted in soft-start periods
// - Release power good when output settled
// - Command bit 7 switches conversion
// - Command bits 5:4 select margining
// - Margin none, high or low
module coos_sequencer (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic vin_above_uvlo_i,
    input wire logic ext_enable_pin_i,
    input wire logic vout_in_window_i,
    input wire logic [1:0] gate_mode_i,
    input wire logic [`COOS_DLY_W-1:0] ton_delay_i,
    input wire logic [`COOS_DLY_W-1:0] toff_delay_i,
    input wire logic [`COOS_SS_W-1:0] soft_start_cycles_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_wdata_i,
    output logic [7:0] conversion_command_o,
    output logic regulate_o,
    output logic [1:0] margin_sel_o,
    output logic power_good_out_o,
    output logic power_good_oe_n_o
);
    // ========================================
    // Command register
    logic [7:0] cmd_reg;
    logic [7:0] cmd_next;
    coos_pkg::coos_margin_t margin_reg;
    coos_pkg::coos_margin_t margin_next;
    logic [1:0] mrg_fld;

    always_comb begin
        cmd_next = cmd_wr_i ? cmd_wdata_i : cmd_reg;
        mrg_fld = cmd_next[`COOS_CMD_MRG_HI:`COOS_CMD_MRG_LO];
        case (mrg_fld)
            `COOS_MRG_FLD_HIGH: margin_next = coos_pkg::COOS_MARGIN_HIGH;
            `COOS_MRG_FLD_LOW: margin_next = coos_pkg::COOS_MARGIN_LOW;
            default: margin_next = coos_pkg::COOS_MARGIN_NONE;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_reg <= `COOS_CMD_RESET;
            margin_reg <= coos_pkg::COOS_MARGIN_NONE;
        end else begin
            cmd_reg <= cmd_next;
            margin_reg <= margin_next;
        end
    end

    assign conversion_command_o = cmd_reg;
    assign margin_sel_o = margin_reg;

    // ========================================
    // Gating condition
    logic gate_ok;
    logic cmd_on;

    assign cmd_on = cmd_reg[`COOS_CMD_ON_BIT];

    always_comb begin
        case (gate_mode_i)
            `COOS_GATE_PIN: gate_ok = vin_above_uvlo_i && ext_enable_pin_i;
            `COOS_GATE_CMD: gate_ok = vin_above_uvlo_i && cmd_on;
            `COOS_GATE_BOTH:
                gate_ok = vin_above_uvlo_i && ext_enable_pin_i && cmd_on;
            default: gate_ok = vin_above_uvlo_i;
        endcase
    end

    // ========================================
    // Sequencer
    coos_pkg::coos_state_t state_reg;
    coos_pkg::coos_state_t state_next;
    logic [`COOS_DLY_W-1:0] dly_cnt_reg;
    logic [`COOS_DLY_W-1:0] dly_cnt_next;
    logic regulate_reg;
    logic regulate_next;
    logic pg_rel_reg;
    logic pg_rel_next;
    logic tick;
    logic restart;

    // Period counter realigns on every state change
    assign restart = (state_next != state_reg);

    coos_period_tick u_tick (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .restart_i(restart),
        .period_i(soft_start_cycles_i),
        .tick_o(tick)
    );

    always_comb begin
        state_next = state_reg;
        dly_cnt_next = dly_cnt_reg;
        case (state_reg)
            coos_pkg::COOS_OFF: begin
                if (gate_ok) begin
                    state_next = coos_pkg::COOS_ON_WAIT;
                end
            end
            coos_pkg::COOS_ON_WAIT: begin
                if (!gate_ok) begin
                    state_next = coos_pkg::COOS_OFF;
                // start after turn-on delay
                // Compare with >= so a delay lowered mid-wait cannot hang
                end else if (dly_cnt_reg >= ton_delay_i) begin
                    state_next = coos_pkg::COOS_SOFT_START;
                end else if (tick) begin
                    dly_cnt_next = dly_cnt_reg + `COOS_DLY_W'(1);
                end
            end
            coos_pkg::COOS_SOFT_START: begin
                if (!gate_ok) begin
                    state_next = coos_pkg::COOS_OFF_WAIT;
                end else if (tick) begin
                    state_next = coos_pkg::COOS_ON;
                end
            end
            coos_pkg::COOS_ON: begin
                if (!gate_ok) begin
                    state_next = coos_pkg::COOS_OFF_WAIT;
                end
            end
            coos_pkg::COOS_OFF_WAIT: begin
                if (gate_ok) begin
                    state_next = coos_pkg::COOS_ON;
                end else if (dly_cnt_reg >= toff_delay_i) begin
                    state_next = coos_pkg::COOS_OFF;
                end else if (tick) begin
                    dly_cnt_next = dly_cnt_reg + `COOS_DLY_W'(1);
                end
            end
            default: begin
                state_next = coos_pkg::COOS_OFF;
            end
        endcase
        if (restart) begin
            dly_cnt_next = '0;
        end
        regulate_next = (state_next == coos_pkg::COOS_SOFT_START) ||
                        (state_next == coos_pkg::COOS_ON) ||
                        (state_next == coos_pkg::COOS_OFF_WAIT);
        pg_rel_next = (state_next == coos_pkg::COOS_ON) && vout_in_window_i;
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= coos_pkg::COOS_OFF;
            dly_cnt_reg <= '0;
            regulate_reg <= 1'b0;
            pg_rel_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            dly_cnt_reg <= dly_cnt_next;
            regulate_reg <= regulate_next;
            pg_rel_reg <= pg_rel_next;
        end
    end

    assign regulate_o = regulate_reg;
    // Open drain: pin only ever pulled low, enable low while pulling
    assign power_good_out_o = 1'b0;
    assign power_good_oe_n_o = pg_rel_reg;

    // ========================================
    // Assertions
    chk_uvlo_holds_off: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_reg == coos_pkg::COOS_OFF) && !vin_above_uvlo_i
        |=> !regulate_o && state_reg == coos_pkg::COOS_OFF)
        else $error("started below uvlo");

    chk_pin_gate_blocks: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_reg == coos_pkg::COOS_OFF) && !ext_enable_pin_i &&
        (gate_mode_i == `COOS_GATE_PIN || gate_mode_i == `COOS_GATE_BOTH)
        |=> state_reg == coos_pkg::COOS_OFF)
        else $error("pin gate ignored");

    chk_cmd_gate_blocks: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_reg == coos_pkg::COOS_OFF) && !cmd_reg[`COOS_CMD_ON_BIT] &&
        (gate_mode_i == `COOS_GATE_CMD || gate_mode_i == `COOS_GATE_BOTH)
        |=> state_reg == coos_pkg::COOS_OFF)
        else $error("command gate ignored");

    chk_ton_expiry: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_reg == coos_pkg::COOS_ON_WAIT) && gate_ok &&
        (dly_cnt_reg == ton_delay_i) |=> regulate_o)
        else $error("no start at turn-on delay end");

    chk_toff_holds: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_reg == coos_pkg::COOS_OFF_WAIT) &&
        (dly_cnt_reg < toff_delay_i) |=> regulate_o)
        else $error("stopped before turn-off delay");

    chk_delay_units: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_reg == coos_pkg::COOS_ON_WAIT) && gate_ok && !tick &&
        (dly_cnt_reg < ton_delay_i) |=> $stable(dly_cnt_reg))
        else $error("delay moved without period tick");

    chk_power_good_out_release: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_reg == coos_pkg::COOS_ON) && gate_ok && vout_in_window_i
        |=> power_good_oe_n_o && regulate_o)
        else $error("power good not released");

    chk_power_good_out_start: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_reg != coos_pkg::COOS_ON) |-> !power_good_oe_n_o ||
        $past(state_reg) == coos_pkg::COOS_ON)
        else $error("power good released during start-up");

    chk_margin_high: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        cmd_wr_i && cmd_wdata_i[`COOS_CMD_MRG_HI:`COOS_CMD_MRG_LO] ==
        `COOS_MRG_FLD_HIGH |=> margin_sel_o == coos_pkg::COOS_MARGIN_HIGH)
        else $error("margin high not selected");

    chk_abort_start: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (state_reg == coos_pkg::COOS_ON_WAIT) && !gate_ok
        |=> state_reg == coos_pkg::COOS_OFF ##1 !regulate_o)
        else $error("pending start not abandoned");

    cov_full_on: cover property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        state_reg == coos_pkg::COOS_SOFT_START ##1
        state_reg == coos_pkg::COOS_ON);
    cov_full_off: cover property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        state_reg == coos_pkg::COOS_OFF_WAIT ##1
        state_reg == coos_pkg::COOS_OFF);
    cov_abort: cover property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        state_reg == coos_pkg::COOS_ON_WAIT ##1
        state_reg == coos_pkg::COOS_OFF);
    cov_power_good_out: cover property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(power_good_oe_n_o));
endmodule

// ### sim/coos_host_model.sv
// Host and external sequencing logic facing the on/off sequencer
`timescale 1ns/1ps
module coos_host_model (
    input wire logic core_clk_i,
    input wire logic chain_i,
    input wire logic pin_req_i,
    input wire logic power_good_out_i,
    input wire logic power_good_oe_n_i,
    output logic ext_enable_pin_o,
    output logic pg_pin_o,
    output logic cmd_wr_o,
    output logic [7:0] cmd_wdata_o
);
    assign pg_pin_o = power_good_oe_n_i ? 1'b1 : power_good_out_i;
    assign ext_enable_pin_o = chain_i ? pg_pin_o : pin_req_i;
    initial begin
        cmd_wr_o = 1'b0;
        cmd_wdata_o = 8'h00;
    end
    // host writes two values back to back
    task automatic write(input logic [7:0] a, input logic [7:0] b);
        @(negedge core_clk_i);
        cmd_wr_o = 1'b1;
        cmd_wdata_o = a;
        @(negedge core_clk_i);
        cmd_wdata_o = b;
        @(negedge core_clk_i);
        cmd_wr_o = 1'b0;
        // Released bus shows the inverse so stale data is never taken
        cmd_wdata_o = ~b;
    endtask
endmodule

// ### sim/test_coos_sequencer.sv
// Self-checking bench of the on/off sequencer
`timescale 1ns/1ps
module test_coos_sequencer;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic vin = 1'b0;
    logic pin = 1'b0;
    logic win = 1'b0;
    logic chain = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [7:0] ton = 8'h00;
    logic [7:0] toff = 8'h00;
    logic [15:0] ss = 16'h0002;
    logic en, wr, reg_on, pg_out, pg_oe_n, pg_pin;
    logic [7:0] wdata, cmd;
    logic [1:0] mrg;
    int errors = 0;
    int check_count = 0;
    always #5 core_clk_i = ~core_clk_i;
    coos_sequencer u_coos_sequencer (.core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i), .vin_above_uvlo_i(vin),
        .ext_enable_pin_i(en), .vout_in_window_i(win),
        .gate_mode_i(mode), .ton_delay_i(ton), .toff_delay_i(toff),
        .soft_start_cycles_i(ss), .cmd_wr_i(wr), .cmd_wdata_i(wdata),
        .conversion_command_o(cmd), .regulate_o(reg_on),
        .margin_sel_o(mrg), .power_good_out_o(pg_out),
        .power_good_oe_n_o(pg_oe_n));
    coos_host_model u_coos_host_model (.core_clk_i(core_clk_i),
        .chain_i(chain), .pin_req_i(pin), .power_good_out_i(pg_out),
        .power_good_oe_n_i(pg_oe_n), .ext_enable_pin_o(en),
        .pg_pin_o(pg_pin), .cmd_wr_o(wr), .cmd_wdata_o(wdata));
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic run(int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    // Delay d in periods: edge seen exactly 2 + d*P falling edges later
    task automatic wait_reg(logic exp, int d, string name);
        int n;
        int p;
        n = 0;
        p = int'(ss);
        while (reg_on !== exp && n < d * p + 4) begin
            run(1);
            n++;
        end
        check(name, 8'(n == d * p + 2 && reg_on === exp), 8'h01);
    endtask
    task automatic t_reset;
        check("rst_reg", reg_on, 1'b0);
        check("rst_cmd", cmd, 8'h00);
        check("rst_mrg", mrg, 2'h0);
        check("rst_pg", pg_pin, 1'b0);
        run(1);
        sys_rst_i = 1'b0;
        $display("test reset done");
    endtask
    task automatic t_uvlo;
        win = 1'b1;
        vin = 1'b1;
        wait_reg(1'b1, 0, "uvlo_on");
        check("pg_early", pg_pin, 1'b0);
        run(5);
        check("pg_set", pg_pin, 1'b1);
        win = 1'b0;
        run(2);
        check("pg_lost", pg_pin, 1'b0);
        win = 1'b1;
        toff = 8'h01;
        vin = 1'b0;
        wait_reg(1'b0, 1, "uvlo_off");
        $display("test uvlo done");
    endtask
    task automatic t_delay;
        for (int i = 1; i < 3; i++) begin
            ss = 16'(2 * i);
            ton = 8'h03;
            toff = 8'h02;
            vin = 1'b1;
            wait_reg(1'b1, 3, "ton");
            run(4 * i);
            vin = 1'b0;
            wait_reg(1'b0, 2, "toff");
            run(4);
        end
        ss = 16'h0002;
        $display("test delay done");
    endtask
    task automatic t_abort;
        logic seen;
        seen = 1'b0;
        vin = 1'b1;
        run(3);
        vin = 1'b0;
        repeat (12) begin
            run(1);
            seen = seen | reg_on;
        end
        check("abort", seen, 1'b0);
        $display("test abort done");
    endtask
    task automatic t_modes;
        logic g;
        ton = 8'h00;
        toff = 8'h00;
        vin = 1'b1;
        for (int i = 0; i < 16; i++) begin
            mode = 2'(i >> 2);
            pin = i[1];
            g = mode == 0 || (mode == 1 && i[1]) || (mode == 2 && i[0]);
            g = g || (mode == 3 && i[1] && i[0]);
            u_coos_host_model.write({i[0], 7'h00}, {i[0], 7'h00});
            run(8);
            check("gate", reg_on, g);
        end
        vin = 1'b0;
        run(8);
        check("uvlo_req", reg_on, 1'b0);
        $display("test modes done");
    endtask
    task automatic t_chain;
        chain = 1'b1;
        mode = 2'h0;
        vin = 1'b1;
        run(8);
        check("chain_on", en, 1'b1);
        vin = 1'b0;
        run(4);
        check("chain_off", en, 1'b0);
        check("chain_reg", reg_on, 1'b0);
        chain = 1'b0;
        $display("test chain done");
    endtask
    task automatic t_margin;
        logic [7:0] codes [4];
        logic [1:0] exp [4];
        codes = '{8'h20, 8'h10, 8'h30, 8'ha0};
        exp = '{coos_pkg::COOS_MARGIN_HIGH, coos_pkg::COOS_MARGIN_LOW,
                coos_pkg::COOS_MARGIN_NONE, coos_pkg::COOS_MARGIN_HIGH};
        for (int i = 0; i < 4; i++) begin
            u_coos_host_model.write(8'h55, codes[i]);
            check("cmd", cmd, codes[i]);
            check("margin", mrg, exp[i]);
        end
        sys_rst_i = 1'b1;
        run(1);
        check("rst_cmd2", cmd, 8'h00);
        sys_rst_i = 1'b0;
        $display("test margin done");
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        run(2);
        t_reset();
        run(2);
        t_uvlo();
        t_delay();
        t_abort();
        t_modes();
        t_chain();
        t_margin();
        complete_run();
    end
    initial begin
        #50000;
        errors++;
        complete_run();
    end
endmodule
